// File: reset_pin_pkg.sv
package reset_pin_pkg;

  // ----------------------------------------------------------------
  // Timing counts in bus cycles and counter width
  // ----------------------------------------------------------------
  localparam int DRIVE_CYCLES = 34;
  localparam int SETTLE_CYCLES = 38;
  localparam int RISE_CYCLES = 10;
  localparam int CNT_W = 6;

  // ----------------------------------------------------------------
  // Reset cause encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_INTERNAL = 2'h2;
  localparam logic [1:0] CAUSE_POWER = 2'h3;

  // ----------------------------------------------------------------
  // Pin signals grouped together, and the sequence states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pinOut;
    logic pinOe;
  } pin_drive_s;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DRIVE,
    ST_SETTLE,
    ST_HELD,
    ST_RISE,
    ST_DEAD
  } seq_state_e;

endpackage

// File: reset_pin_sequencer.sv
`timescale 1ns/1ps
// How it works
// R1: Latch reset cause on the same edge the pin sequence starts.
// R2: Drive pin low 34 cycles, then release.
// R3: Sample pin 38 cycles after release.
// R4: After long external hold, sample 10 cycles post-rise.
// R5: Falling edge at sample point hangs device.
// R6: Outside sources stay off pin 10 cycles.
// R7: High sample ends sequence, releases internal reset.
module reset_pin_sequencer #(
  // Counter width and timing counts in bus cycles
  parameter int CNT_W = reset_pin_pkg::CNT_W,
  parameter int DRIVE_CYCLES = reset_pin_pkg::DRIVE_CYCLES,
  parameter int SETTLE_CYCLES = reset_pin_pkg::SETTLE_CYCLES,
  parameter int RISE_CYCLES = reset_pin_pkg::RISE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Reset sources
  input wire logic internalReset,
  input wire logic powerOnReset,
  // Reset pin, active low, open drain
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // Status
  output logic coreResetN,
  output logic hung,
  output logic [1:0] resetCause
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reset_pin_pkg::seq_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] cause_reg, cause_next;
  logic pinPrev_reg;
  reset_pin_pkg::pin_drive_s drive_reg, drive_next;
  logic coreN_reg, coreN_next;
  logic hung_reg, hung_next;

  // ----------------------------------------------------------------
  // Count end points
  // ----------------------------------------------------------------
  // The counter starts at zero, so each end point sits one below its count.
  localparam logic [CNT_W-1:0] DRIVE_LAST =
    CNT_W'(DRIVE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST =
    CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] RISE_LAST =
    CNT_W'(RISE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire pinFall = pinPrev_reg & ~pinIn;
  // Our own drive is masked, so the sequence never retriggers itself.
  wire pinTrig = ~pinIn & ~drive_reg.pinOe;
  wire anyTrig = internalReset | pinTrig;
  // An internal request wins when both sources arrive together.
  wire [1:0] newCause = internalReset ? reset_pin_pkg::CAUSE_INTERNAL
                                      : reset_pin_pkg::CAUSE_PIN;
  wire [CNT_W-1:0] cntInc = cnt_reg + CNT_W'(1);
  wire driveDone = (cnt_reg == DRIVE_LAST);
  wire settleDone = (cnt_reg == SETTLE_LAST);
  wire riseDone = (cnt_reg == RISE_LAST);

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cause_next = cause_reg;
    drive_next = drive_reg;
    coreN_next = coreN_reg;
    case (state_reg)
      reset_pin_pkg::ST_RUN: begin
        if (anyTrig) begin
          cause_next = newCause; // R1
          coreN_next = 1'b0;
          drive_next = '{pinOut: 1'b0, pinOe: 1'b1}; // R2
          cnt_next = '0;
          state_next = reset_pin_pkg::ST_DRIVE;
        end
      end
      reset_pin_pkg::ST_DRIVE: begin
        cnt_next = cntInc;
        if (driveDone) begin
          drive_next = '{pinOut: 1'b1, pinOe: 1'b0}; // R2
          cnt_next = '0;
          state_next = reset_pin_pkg::ST_SETTLE;
        end
      end
      reset_pin_pkg::ST_SETTLE: begin
        cnt_next = cntInc;
        // A falling edge landing on the sample point locks the part up.
        if (settleDone) begin
          if (pinFall) begin
            state_next = reset_pin_pkg::ST_DEAD; // R5
          end else if (pinIn) begin
            coreN_next = 1'b1; // R7
            state_next = reset_pin_pkg::ST_RUN; // R3
          end else begin
            state_next = reset_pin_pkg::ST_HELD; // R4
          end
        end
      end
      reset_pin_pkg::ST_HELD: begin
        if (pinIn) begin
          cnt_next = '0;
          state_next = reset_pin_pkg::ST_RISE; // R4
        end
      end
      reset_pin_pkg::ST_RISE: begin
        cnt_next = cntInc;
        if (riseDone) begin
          if (pinFall) begin
            state_next = reset_pin_pkg::ST_DEAD; // R5
          end else if (pinIn) begin
            coreN_next = 1'b1; // R7
            state_next = reset_pin_pkg::ST_RUN; // R4
          end else begin
            state_next = reset_pin_pkg::ST_HELD;
          end
        end
      end
      reset_pin_pkg::ST_DEAD: begin
        // Only a power-on reset or a low nrst leaves this state; the pin is ignored.
        coreN_next = 1'b0; // R5
      end
      default: state_next = reset_pin_pkg::ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Power-on and the external reset input share one restart path.
  wire startOver = !nrst || powerOnReset;

  // The lockup flag is registered so that it cannot glitch on a state change.
  assign hung_next = (state_next == reset_pin_pkg::ST_DEAD); // R5

  always_ff @(posedge clk) begin
    if (startOver) begin
      state_reg <= reset_pin_pkg::ST_DRIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One counter serves all three timed phases; each phase restarts it at zero.
  always_ff @(posedge clk) begin
    if (startOver) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  // The cause survives the whole sequence and is only replaced from run, or by a restart, which loads the power cause.
  always_ff @(posedge clk) begin
    if (startOver) begin
      cause_reg <= reset_pin_pkg::CAUSE_POWER;
    end else begin
      cause_reg <= cause_next;
    end
  end

  always_ff @(posedge clk) begin
    if (startOver) begin
      coreN_reg <= 1'b0;
    end else begin
      coreN_reg <= coreN_next;
    end
  end

  always_ff @(posedge clk) begin
    if (startOver) begin
      hung_reg <= 1'b0;
    end else begin
      hung_reg <= hung_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // The pin is only ever pulled low; released means the output enable is off.
  always_ff @(posedge clk) begin
    if (startOver) begin
      drive_reg <= '{pinOut: 1'b0, pinOe: 1'b1};
    end else begin
      drive_reg <= drive_next;
    end
  end

  // The previous level resets high, as the idle pin does, so no false fall appears.
  always_ff @(posedge clk) begin
    if (startOver) begin
      pinPrev_reg <= 1'b1;
    end else begin
      pinPrev_reg <= pinIn;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pinOut = drive_reg.pinOut;
  assign pinOe = drive_reg.pinOe;
  assign coreResetN = coreN_reg;
  assign hung = hung_reg;
  assign resetCause = cause_reg;

endmodule

// File: reset_pin_sequencer_sva.sv
`timescale 1ns/1ps
module reset_pin_sequencer_sva (
  // Observed ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic internalReset,
  input wire logic powerOnReset,
  input wire logic pinIn,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic coreResetN,
  input wire logic hung,
  input wire logic [1:0] resetCause
);
  // ----------------------------------------
  // Saturating count since release, so a long hold stays marked.
  // ----------------------------------------
  logic [6:0] relCnt;
  always_ff @(posedge clk) relCnt <= pinOe ? 7'h00 : relCnt + {6'h00, relCnt != 7'h7F};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || powerOnReset);
  sequence settled;
    $fell(pinOe) ##37 1'b1;
  endsequence
  sequence long_rise;
    (relCnt > 7'h28 && !coreResetN && !hung && $rose(pinIn)) ##1 pinIn [*8] ##1 pinIn [*2];
  endsequence
  a_cause_internal: assert property (
    coreResetN && internalReset |=> resetCause == reset_pin_pkg::CAUSE_INTERNAL && pinOe
  ) else $error("cause not internal");
  a_cause_pin: assert property (
    coreResetN && !internalReset && !pinIn |=> resetCause == reset_pin_pkg::CAUSE_PIN
  ) else $error("cause not pin");
  a_drive_len: assert property (
    $fell(coreResetN) && $past(nrst) |-> ##33 pinOe ##1 !pinOe
  ) else $error("drive length wrong");
  a_sample_high: assert property (
    settled ##0 pinIn |=> coreResetN) else $error("no release");
  a_sample_low: assert property (
    settled ##0 !pinIn |=> !coreResetN) else $error("released while low");
  a_rise_sample: assert property (
    long_rise |-> !coreResetN ##1 coreResetN) else $error("rise sample wrong");
  a_fall_hangs: assert property (
    settled ##0 $fell(pinIn) |=> hung) else $error("no lockup");
  a_dead_stays: assert property (
    hung |=> hung && !coreResetN) else $error("lockup left");
  a_drive_low: assert property (
    pinOe |-> !pinOut) else $error("pin driven high");
endmodule
bind reset_pin_sequencer reset_pin_sequencer_sva chk (.clk(clk), .nrst(nrst),
  .internalReset(internalReset), .powerOnReset(powerOnReset), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe), .coreResetN(coreResetN), .hung(hung),
  .resetCause(resetCause));

// File: reset_source_model.sv
`timescale 1ns/1ps
module reset_source_model (
  // Clock
  input wire logic clk,
  // Pin and request
  input wire logic pinLevel,
  input wire logic holdReq,
  output logic pullLow
);
  // A supervisor that waits out the quiet time before pulling again.
  logic [3:0] quiet;
  always_ff @(posedge clk) begin
    quiet <= pinLevel ? quiet + {3'h0, quiet != 4'hA} : 4'h0;
    pullLow <= holdReq && (pullLow || quiet == 4'hA);
  end
endmodule

// File: reset_pin_sequencer_bench.sv
`timescale 1ns/1ps
module reset_pin_sequencer_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic internalReset = 1'b0;
  logic powerOnReset = 1'b0;
  logic holdReq = 1'b0;
  logic pinIn, pullLow, pinOut, pinOe, coreResetN, hung;
  logic [1:0] resetCause;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  assign pinIn = !((pinOe && !pinOut) || pullLow);
  reset_pin_sequencer uut (.clk(clk), .nrst(nrst), .internalReset(internalReset),
    .powerOnReset(powerOnReset), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .coreResetN(coreResetN), .hung(hung), .resetCause(resetCause));
  reset_source_model ext (.clk(clk), .pinLevel(pinIn), .holdReq(holdReq), .pullLow(pullLow));
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic internal_trigger();
    internalReset = 1'b1;
    wait_n(1);
    internalReset = 1'b0;
    wait_n(1);
    chk("cause", reset_pin_pkg::CAUSE_INTERNAL, resetCause);
    wait_n(reset_pin_pkg::DRIVE_CYCLES - 2);
    chk("drive", 2'h1, {1'b0, pinOe});
    chk("pin level", 2'h0, {1'b0, pinOut});
    wait_n(1);
    chk("release", 2'h0, {1'b0, pinOe});
    wait_n(reset_pin_pkg::SETTLE_CYCLES - 1);
    chk("core", 2'h0, {1'b0, coreResetN});
    wait_n(1);
    chk("core", 2'h1, {1'b0, coreResetN});
  endtask
  task automatic pin_hold();
    holdReq = 1'b1;
    wait_n(5);
    chk("cause", reset_pin_pkg::CAUSE_PIN, resetCause);
    wait_n(95);
    holdReq = 1'b0;
    wait_n(reset_pin_pkg::RISE_CYCLES + 1);
    chk("core", 2'h0, {1'b0, coreResetN});
    wait_n(1);
    chk("core", 2'h1, {1'b0, coreResetN});
  endtask
  task automatic late_fall();
    internalReset = 1'b1;
    wait_n(1);
    internalReset = 1'b0;
    wait_n(reset_pin_pkg::DRIVE_CYCLES + reset_pin_pkg::SETTLE_CYCLES - 2);
    holdReq = 1'b1;
    wait_n(2);
    chk("hung", 2'h1, {1'b0, hung});
    holdReq = 1'b0;
    wait_n(5);
    chk("hung", 2'h1, {1'b0, hung});
    powerOnReset = 1'b1;
    wait_n(1);
    powerOnReset = 1'b0;
    wait_n(80);
    chk("cause", reset_pin_pkg::CAUSE_POWER, resetCause);
    chk("core", 2'h1, {1'b0, coreResetN});
  endtask
  // Safety net against a sequencer that never lets go.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    wait_n(2);
    nrst = 1'b1;
    wait_n(80);
    chk("core", 2'h1, {1'b0, coreResetN});
    internal_trigger();
    pin_hold();
    late_fall();
    results();
  end
endmodule
